// File: include/adc_seq_pkg.sv
// Package: register map, field positions and timing constants of the converter control
package adc_seq_pkg;
  localparam int         ADDR_W          = 12;
  // Register byte addresses
  localparam logic [11:0] OFS_CTRL_STATUS = 12'h000;
  localparam logic [11:0] OFS_INPUT_SEL   = 12'h004;
  localparam logic [11:0] OFS_TRIG_SEL    = 12'h008;
  localparam logic [11:0] OFS_RESULT_LOW  = 12'h00c;
  localparam logic [11:0] OFS_RESULT_HIGH = 12'h010;
  localparam logic [11:0] OFS_EVT_STATUS  = 12'h014;
  localparam logic [11:0] OFS_EVT_MASK    = 12'h018;
  localparam logic [11:0] OFS_IRQ_ACK     = 12'h01c;
  // Control and status register fields
  localparam int BIT_ENABLE   = 7;
  localparam int BIT_START    = 6;
  localparam int BIT_AUTO     = 5;
  localparam int BIT_DONE     = 4;
  localparam int BIT_IRQ_EN   = 3;
  localparam int PRESC_MSB    = 2;
  localparam int PRESC_W      = 3;
  localparam int SEL_W        = 5;
  localparam int TRIG_W       = 3;
  localparam int RES_W        = 10;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Event status bits
  localparam int EVT_DONE     = 0;
  localparam int EVT_OVERRUN  = 1;
  localparam int EVT_W        = 2;
  // Conversion lengths in ADC clock cycles
  localparam logic [4:0] CONV_FIRST_CYC  = 5'h19;
  localparam logic [4:0] CONV_NORMAL_CYC = 5'h0d;
  localparam logic [2:0] TRIG_FREE_RUN   = 3'h0;
  localparam logic [4:0] SEL_RESERVED    = 5'h0f;
  localparam int DIV_W = 7;
  typedef enum logic [1:0] {conv_idle, conv_run} conv_state_t;
endpackage

// File: rtl/adc_clock_divider.sv
// ADC clock enable generator selected by the prescale code
`timescale 1ns/100ps
module adc_clock_divider
  import adc_seq_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               run,
  input  wire logic [PRESC_W-1:0] clock_prescale_select,
  output logic                    adc_tick
);
  logic [DIV_W-1:0] count_ff;
  logic [DIV_W-1:0] limit;

  // Codes 0 and 1 both divide by two
  always_comb begin
    if (clock_prescale_select == 3'h0) begin
      limit = 7'h01;
    end else begin
      limit = DIV_W'((8'h01 << clock_prescale_select) - 8'h01); // R13
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= '0;
    end else if (!run || count_ff >= limit) begin
      count_ff <= '0;
    end else begin
      count_ff <= count_ff + 7'h01;
    end
  end

  assign adc_tick = run && (count_ff >= limit);
endmodule

// File: rtl/adc_sequencing_control.sv
// Converter sequencing control with APB register access
// Summary of operation
// [R1] New input selection made during a conversion takes effect only when it completes.
// [R2] Codes 0-10 single-ended pins, then sensor, bandgap, supply/4, ground; 15 reserved.
// [R3] Top bit set selects differential pairs; even code gain 8, odd gain 20.
// [R4] Enable bit powers converter; clearing it aborts any running conversion.
// [R5] Start bit starts one conversion, or first conversion in free-running mode.
// [R6] First conversion after enable lasts 25 ADC cycles, later ones 13.
// [R7] Start bit reads one while converting; writing zero has no effect.
// [R8] Auto trigger starts a conversion on each rising edge of selected source; edges arriving while a conversion runs are ignored.
// [R9] Done flag sets when conversion ends and result registers are updated.
// [R10] Interrupt requested while flag, interrupt enable and global enable are set.
// [R11] Flag cleared by interrupt vector acknowledge or writing one; zero ignored.
// [R12] Software read-modify-write of control may clear a pending flag.
// [R13] Prescale code divides system clock by 2,2,4,8,16,32,64,128.
// [R14] Control and status register resets to all zero.
// [R15] Trigger source codes 0 free run, 1-7 the listed peripheral events.
// [R16] Source switch from clear to set makes an edge; free run never triggers.
// [R17] Reading result low byte freezes result until high byte is read.
// [R18] ADC clock edges are counted; result captured at conversion length.
// [R19] Free-running mode restarts immediately after each completion while enabled.
`timescale 1ns/100ps
module adc_sequencing_control
  import adc_seq_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              global_irq_enable,
  input  wire logic              irq_vector_ack,
  input  wire logic [6:0]        trigger_sources,
  input  wire logic [RES_W-1:0]  core_result,
  output logic                   core_power,
  output logic                   core_sample,
  output logic [SEL_W-1:0]       core_input_select,
  output logic                   core_differential,
  output logic                   core_gain_20x,
  output logic                   core_channel_valid,
  output logic                   conversion_irq,
  output logic                   irq
);
  logic [7:0]        ctrl_ff;
  logic [SEL_W-1:0]  sel_reg_ff;
  logic [SEL_W-1:0]  sel_live_ff;
  logic [TRIG_W-1:0] trig_sel_ff;
  logic [RES_W-1:0]  result_ff;
  logic              frozen_ff;
  logic              first_ff;
  logic [4:0]        cyc_ff;
  logic [6:0]        trig_s1_ff;
  logic [6:0]        trig_s2_ff;
  logic              trig_level_ff;
  logic [EVT_W-1:0]  evt_ff;
  logic [EVT_W-1:0]  mask_ff;
  logic [31:0]       nxt_prdata;
  logic [31:0]       prdata_ff;
  logic              diff_ff;
  logic              gain_ff;
  logic              valid_ff;
  conv_state_t       state_ff;
  logic              adc_tick;
  logic              wr_en;
  logic              rd_en;
  logic              rd_setup;
  logic              lo_take;
  logic              wr_ctrl;
  logic              start_req;
  logic              conv_done;
  logic              trig_level;
  logic              trig_edge;
  logic              enable;
  logic              busy;
  logic [4:0]        conv_len;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a == OFS_CTRL_STATUS) || (a == OFS_INPUT_SEL) || (a == OFS_TRIG_SEL)
            || (a == OFS_RESULT_LOW) || (a == OFS_RESULT_HIGH) || (a == OFS_EVT_STATUS)
            || (a == OFS_EVT_MASK) || (a == OFS_IRQ_ACK);
  endfunction

  // Access-phase write to one register offset
  function automatic logic wr_to(input logic en, input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
    wr_to = en && (a == ofs);
  endfunction

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_hit(paddr);
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  // Read data and the result freeze are taken in the setup phase
  assign rd_setup = psel && !penable && !pwrite;
  assign lo_take  = rd_setup && (paddr == OFS_RESULT_LOW);
  assign wr_ctrl = wr_en && (paddr == OFS_CTRL_STATUS);
  assign enable  = ctrl_ff[BIT_ENABLE];
  assign busy    = (state_ff == conv_run);

  adc_clock_divider u_div (
    .pclk                  (pclk),
    .presetn               (presetn),
    .run                   (enable),
    .clock_prescale_select (ctrl_ff[PRESC_MSB -: PRESC_W]),
    .adc_tick              (adc_tick)
  );

  // Trigger inputs come from other logic: two-stage synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_s1_ff <= '0;
      trig_s2_ff <= '0;
    end else begin
      trig_s1_ff <= trigger_sources;
      trig_s2_ff <= trig_s1_ff;
    end
  end

  // Source 0 is free running and never forms a trigger level
  always_comb begin
    if (trig_sel_ff == TRIG_FREE_RUN) begin
      trig_level = 1'b0; // R16
    end else begin
      trig_level = trig_s2_ff[trig_sel_ff - 3'h1]; // R15
    end
  end

  // Level history follows the selected source, so switching from a clear to a set source gives an edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_level_ff <= 1'b0;
    end else begin
      trig_level_ff <= trig_level; // R16
    end
  end

  assign trig_edge = ctrl_ff[BIT_AUTO] && trig_level && !trig_level_ff; // R8

  // Start sources: software write of one with enable set, and auto trigger edge
  always_comb begin
    start_req = 1'b0;
    if (wr_ctrl && pwdata[BIT_ENABLE] && pwdata[BIT_START]) begin
      start_req = 1'b1; // R5
    end
    if (enable && trig_edge) begin
      start_req = 1'b1; // R8
    end
  end

  assign conv_len  = first_ff ? CONV_FIRST_CYC : CONV_NORMAL_CYC; // R6
  assign conv_done = busy && adc_tick && (cyc_ff == conv_len - 5'h01); // R18

  // Conversion sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= conv_idle;
      cyc_ff   <= '0;
    end else if (!enable && !(wr_ctrl && pwdata[BIT_ENABLE])) begin
      state_ff <= conv_idle; // R4
      cyc_ff   <= '0;
    end else begin
      unique case (state_ff)
        conv_idle: begin
          cyc_ff <= '0;
          if (start_req) begin
            state_ff <= conv_run;
          end
        end
        conv_run: begin
          if (wr_ctrl && !pwdata[BIT_ENABLE]) begin
            state_ff <= conv_idle; // R4
            cyc_ff   <= '0;
          end else if (conv_done) begin
            cyc_ff <= '0;
            // Free running: auto trigger on with source 0 restarts at once
            if (!(ctrl_ff[BIT_AUTO] && trig_sel_ff == TRIG_FREE_RUN)) begin
              state_ff <= conv_idle; // R19
            end
          end else if (adc_tick) begin
            cyc_ff <= cyc_ff + 5'h01; // R18
          end
        end
      endcase
    end
  end

  // First conversion after enable gets the longer initialisation length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_ff <= 1'b1;
    end else if (!enable) begin
      first_ff <= 1'b1; // R6
    end else if (conv_done) begin
      first_ff <= 1'b0;
    end
  end

  // Control and status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET; // R14
    end else begin
      if (wr_ctrl) begin
        ctrl_ff[BIT_ENABLE]          <= pwdata[BIT_ENABLE];
        ctrl_ff[BIT_AUTO]            <= pwdata[BIT_AUTO];
        ctrl_ff[BIT_IRQ_EN]          <= pwdata[BIT_IRQ_EN];
        ctrl_ff[PRESC_MSB -: PRESC_W] <= pwdata[PRESC_MSB -: PRESC_W];
      end
      ctrl_ff[BIT_START] <= 1'b0;
      // Done flag: hardware set wins over ack or write-one clear
      if (conv_done) begin
        ctrl_ff[BIT_DONE] <= 1'b1; // R9
      end else if (irq_vector_ack || (wr_ctrl && pwdata[BIT_DONE])) begin
        ctrl_ff[BIT_DONE] <= 1'b0; // R11
      end
    end
  end

  // Software copy of the input selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg_ff <= '0;
    end else if (wr_to(wr_en, paddr, OFS_INPUT_SEL)) begin
      sel_reg_ff <= pwdata[SEL_W-1:0];
    end
  end

  // Trigger source selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_sel_ff <= '0;
    end else if (wr_to(wr_en, paddr, OFS_TRIG_SEL)) begin
      trig_sel_ff <= pwdata[TRIG_W-1:0];
    end
  end

  // Copy seen by the core, with its decode, moves only between conversions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_live_ff <= '0;
      diff_ff     <= 1'b0;
      gain_ff     <= 1'b0;
      valid_ff    <= 1'b1;
    end else if (!busy || conv_done) begin
      sel_live_ff <= sel_reg_ff; // R1
      diff_ff     <= sel_reg_ff[SEL_W-1]; // R3
      gain_ff     <= sel_reg_ff[SEL_W-1] && sel_reg_ff[0]; // R3
      valid_ff    <= (sel_reg_ff != SEL_RESERVED); // R2
    end
  end

  assign core_input_select  = sel_live_ff; // R2
  assign core_differential  = diff_ff; // R3
  assign core_gain_20x      = gain_ff; // R3
  assign core_channel_valid = valid_ff; // R2
  assign core_power         = enable; // R4
  assign core_sample        = busy;

  // Result register, frozen between low-byte and high-byte reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_ff <= '0;
    end else if (conv_done && !frozen_ff && !lo_take) begin
      result_ff <= core_result; // R18
    end
  end

  // Freeze starts when the low byte is captured for the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frozen_ff <= 1'b0;
    end else if (lo_take) begin
      frozen_ff <= 1'b1; // R17
    end else if (rd_en && paddr == OFS_RESULT_HIGH) begin
      frozen_ff <= 1'b0; // R17
    end
  end

  // Event mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff <= '0;
    end else if (wr_to(wr_en, paddr, OFS_EVT_MASK)) begin
      mask_ff <= pwdata[EVT_W-1:0];
    end
  end

  // Event status: sticky, set wins; a read clears only the bits it reported
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_ff <= '0;
    end else begin
      for (int i = 0; i < EVT_W; i++) begin
        if (rd_en && paddr == OFS_EVT_STATUS && prdata_ff[i]) begin
          evt_ff[i] <= 1'b0;
        end
      end
      if (conv_done) begin
        evt_ff[EVT_DONE] <= 1'b1;
      end
      if (conv_done && (frozen_ff || lo_take)) begin
        evt_ff[EVT_OVERRUN] <= 1'b1;
      end
    end
  end

  assign conversion_irq = ctrl_ff[BIT_DONE] && ctrl_ff[BIT_IRQ_EN]
                       && global_irq_enable; // R10
  assign irq = |(evt_ff & mask_ff);

  always_comb begin
    nxt_prdata = '0;
    unique case (paddr)
      OFS_CTRL_STATUS: begin
        nxt_prdata[7:0] = ctrl_ff;
        nxt_prdata[BIT_START] = busy; // R7
      end
      OFS_INPUT_SEL:   nxt_prdata[SEL_W-1:0] = sel_reg_ff;
      OFS_TRIG_SEL:    nxt_prdata[TRIG_W-1:0] = trig_sel_ff;
      OFS_RESULT_LOW:  nxt_prdata[7:0] = result_ff[7:0];
      OFS_RESULT_HIGH: nxt_prdata[RES_W-9:0] = result_ff[RES_W-1:8];
      OFS_EVT_STATUS:  nxt_prdata[EVT_W-1:0] = evt_ff;
      OFS_EVT_MASK:    nxt_prdata[EVT_W-1:0] = mask_ff;
      default:         nxt_prdata = '0;
    endcase
  end

  // Read data is taken in the setup phase and stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= '0;
    end else if (rd_setup) begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata = prdata_ff;
endmodule

// File: test/adc_seq_properties.sv
// Port-level checker for the converter sequencing control
`timescale 1ns/100ps
module adc_seq_checker
  import adc_seq_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              global_irq_enable,
  input wire logic              core_power,
  input wire logic              core_sample,
  input wire logic [SEL_W-1:0]  core_input_select,
  input wire logic              core_differential,
  input wire logic              core_gain_20x,
  input wire logic              core_channel_valid,
  input wire logic              conversion_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_diff_top: assert property (core_differential == core_input_select[4])
    else $error("differential flag mismatch");
  chk_gain_odd: assert property (core_gain_20x == (core_input_select[4] & core_input_select[0]))
    else $error("gain selection mismatch");
  chk_chan_valid: assert property (core_channel_valid == (core_input_select != SEL_RESERVED))
    else $error("channel valid mismatch");
  chk_sample_power: assert property (core_sample |-> core_power)
    else $error("sampling while unpowered");
  chk_power_write: assert property ($rose(core_power) |->
    $past(psel && penable && pwrite && paddr == OFS_CTRL_STATUS))
    else $error("power rose without control write");
  chk_power_abort: assert property ($fell(core_power) |-> !core_sample)
    else $error("conversion not aborted");
  chk_min_length: assert property ($rose(core_sample) |-> (core_sample || !core_power)[*8])
    else $error("conversion too short");
  chk_irq_global: assert property (conversion_irq |-> global_irq_enable)
    else $error("interrupt without global enable");

  cov_start: cover property ($rose(core_sample));
  cov_end: cover property ($fell(core_sample));
  cov_irq: cover property (conversion_irq);
endmodule

bind adc_sequencing_control adc_seq_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .global_irq_enable, .core_power, .core_sample, .core_input_select,
  .core_differential, .core_gain_20x, .core_channel_valid, .conversion_irq);

// File: test/tb_top.sv
// Self-checking bench for the converter sequencing control
`timescale 1ns/100ps
`define CK(n, e, a) begin checks_done++; if ((a) !== (e)) begin err_total++; \
$display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module tb_top
  import adc_seq_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, gie, ack, se;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  trg;
  logic [9:0]  res;
  logic [4:0]  sel;
  logic        pready, pslverr, pwr, smp, dif, g20, cv, cirq, irq;
  int          err_total, checks_done, cyc, n;

  adc_sequencing_control DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .global_irq_enable(gie), .irq_vector_ack(ack),
    .trigger_sources(trg), .core_result(res), .core_power(pwr), .core_sample(smp),
    .core_input_select(sel), .core_differential(dif), .core_gain_20x(g20),
    .core_channel_valid(cv), .conversion_irq(cirq), .irq);

  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  task automatic complete_run;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // One APB transfer, then one idle edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
    if (k >= 20) begin
      err_total++;
      complete_run();
    end
  endtask

  task automatic wt(input logic v);
    n = 0;
    while (smp !== v && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 5000) begin
      err_total++;
      complete_run();
    end
  endtask

  task automatic conv(input logic [7:0] c, input int e);
    int s;
    bus(1, OFS_CTRL_STATUS, {24'h0, c});
    s = cyc;
    wt(0);
    `CK("len", 1'b1, (cyc - s >= e - e / 13 && cyc - s <= e + 1))
  endtask

  task automatic t_single;
    int s;
    gie <= 1;
    bus(1, OFS_EVT_MASK, 1);
    bus(1, OFS_CTRL_STATUS, 32'hc8);
    s = cyc;
    bus(0, OFS_CTRL_STATUS, 0);
    `CK("busy", 1'b1, rd[BIT_START])
    bus(1, OFS_CTRL_STATUS, 32'h88);
    bus(1, OFS_INPUT_SEL, 32'h1e);
    `CK("hold", 1'b1, sel !== 5'h1e)
    bus(0, OFS_CTRL_STATUS, 0);
    `CK("w0", 1'b1, rd[BIT_START])
    wt(0);
    `CK("first", 1'b1, (cyc - s >= 47 && cyc - s <= 55))
    `CK("sel", 5'h1e, sel)
    `CK("g8", 2'b10, {dif, g20})
    bus(0, OFS_CTRL_STATUS, 0);
    `CK("done", 2'b01, {rd[BIT_START], rd[BIT_DONE]})
    `CK("cirq", 2'b11, {cirq, irq})
    gie <= 0;
    bus(0, OFS_EVT_STATUS, 0);
    `CK("evt", 1'b1, rd[EVT_DONE])
    `CK("gie", 2'b00, {cirq, irq})
    bus(0, OFS_RESULT_LOW, 0);
    `CK("lo", 8'ha5, rd[7:0])
    bus(0, OFS_RESULT_HIGH, 0);
    `CK("hi", 2'h2, rd[1:0])
    bus(1, OFS_CTRL_STATUS, 32'h88);
    bus(0, OFS_CTRL_STATUS, 0);
    `CK("w1c0", 1'b1, rd[BIT_DONE])
    bus(1, OFS_CTRL_STATUS, 32'h98);
    bus(0, OFS_CTRL_STATUS, 0);
    `CK("w1c1", 1'b0, rd[BIT_DONE])
    bus(1, OFS_EVT_MASK, 0);
    conv(8'hc8, 26);
    `CK("mask", 1'b0, irq)
    ack <= 1;
    @(posedge pclk);
    ack <= 0;
    bus(0, OFS_CTRL_STATUS, 0);
    `CK("ack", 1'b0, rd[BIT_DONE])
  endtask

  task automatic t_mux;
    bus(1, OFS_INPUT_SEL, 32'h0f);
    @(posedge pclk);
    `CK("resv", 1'b0, cv)
    bus(1, OFS_INPUT_SEL, 32'h13);
    @(posedge pclk);
    `CK("g20", 3'b111, {cv, dif, g20})
    bus(1, OFS_INPUT_SEL, 32'h0b);
    @(posedge pclk);
    `CK("sensor", 3'b100, {cv, dif, g20})
    bus(0, OFS_INPUT_SEL, 0);
    `CK("selrd", 5'h0b, rd[4:0])
  endtask

  task automatic t_freeze;
    res <= 10'h15a;
    bus(0, OFS_RESULT_LOW, 0);
    conv(8'hc8, 26);
    bus(0, OFS_RESULT_HIGH, 0);
    `CK("frozen", 2'h2, rd[1:0])
    bus(0, OFS_EVT_STATUS, 0);
    `CK("overrun", 2'b11, rd[1:0])
    conv(8'hc8, 26);
    bus(0, OFS_RESULT_LOW, 0);
    `CK("fresh", 8'h5a, rd[7:0])
    bus(0, OFS_RESULT_HIGH, 0);
    `CK("freshhi", 2'h1, rd[1:0])
  endtask

  task automatic t_trig;
    bus(1, OFS_CTRL_STATUS, 32'ha0);
    for (int k = 1; k < 8; k++) begin
      bus(1, OFS_TRIG_SEL, k);
      trg[k-1] <= 1'b1;
      repeat (8) @(posedge pclk);
      `CK("trig", 1'b1, smp)
      trg <= 0;
      wt(0);
    end
    trg <= 7'h01;
    bus(1, OFS_TRIG_SEL, 2);
    `CK("quiet", 1'b0, smp)
    bus(1, OFS_TRIG_SEL, 1);
    repeat (6) @(posedge pclk);
    `CK("swedge", 1'b1, smp)
    trg <= 0;
    wt(0);
    bus(1, OFS_TRIG_SEL, 0);
    repeat (8) @(posedge pclk);
    `CK("freeidle", 1'b0, smp)
  endtask

  initial begin
    {presetn, psel, penable, pwrite, gie, ack} = 0;
    paddr = 0;
    pwdata = 0;
    trg = 0;
    res = 10'h2a5;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    bus(0, OFS_CTRL_STATUS, 0);
    `CK("rst", 8'h00, rd[7:0])
    bus(0, 12'h020, 0);
    `CK("slverr", 1'b1, se)
    t_mux();
    t_single();
    t_freeze();
    for (int c = 1; c < 8; c++) begin
      conv(8'hc0 | 8'(c), 13 * (c < 2 ? 2 : 1 << c));
    end
    t_trig();
    bus(1, OFS_CTRL_STATUS, 32'he0);
    repeat (60) @(posedge pclk);
    `CK("free", 1'b1, smp)
    bus(0, OFS_CTRL_STATUS, 0);
    `CK("fdone", 2'b11, {rd[BIT_START], rd[BIT_DONE]})
    bus(1, OFS_CTRL_STATUS, 32'h00);
    `CK("off", 2'b00, {pwr, smp})
    repeat (30) @(posedge pclk);
    `CK("stay", 1'b0, smp)
    complete_run();
  end
endmodule
